//--- verilog/sad_pkg.sv
// constants and types shared by the scalar alu format decoder
package sad_pkg;

  typedef enum logic [1:0] {FMT_NONE, FMT_TWO_SRC, FMT_IMM, FMT_ONE_SRC} sad_fmt_t;

  typedef enum logic [3:0] {
    OPK_SCALAR_GENERAL_REGISTER, OPK_VECTOR_CONDITION_LOW_HALF, OPK_VECTOR_CONDITION_HIGH_HALF, OPK_TRAP, OPK_M0, OPK_NULL, OPK_EXECUTE_MASK_LOW_HALF,
    OPK_EXECUTE_MASK_HIGH_HALF, OPK_CONST, OPK_APERTURE, OPK_LITERAL, OPK_IMM, OPK_RESERVED
  } sad_opk_t;

  typedef enum logic [0:0] {ST_IDLE, ST_LIT} sad_st_t;

  // fixed format patterns
  localparam logic [8:0] ONE_SRC_PAT = 9'h17D;
  localparam logic [3:0] IMM_PAT     = 4'hB;
  localparam logic [1:0] TWO_SRC_PAT = 2'h2;

  // operand code boundaries
  localparam logic [7:0] CODE_SCALAR_GENERAL_REGISTER_LAST = 8'h69;
  localparam logic [7:0] CODE_VECTOR_CONDITION_LOW_HALF    = 8'h6A;
  localparam logic [7:0] CODE_VECTOR_CONDITION_HIGH_HALF    = 8'h6B;
  localparam logic [7:0] CODE_TRAP_LAST = 8'h7B;
  localparam logic [7:0] CODE_M0        = 8'h7C;
  localparam logic [7:0] CODE_NULL      = 8'h7D;
  localparam logic [7:0] CODE_EXECUTE_MASK_LOW_HALF   = 8'h7E;
  localparam logic [7:0] CODE_EXECUTE_MASK_HIGH_HALF   = 8'h7F;
  localparam logic [7:0] CODE_ZERO      = 8'h80;
  localparam logic [7:0] CODE_POS_LAST  = 8'hC0;
  localparam logic [7:0] CODE_NEG_LAST  = 8'hD0;
  localparam logic [7:0] CODE_APER_1ST  = 8'hEB;
  localparam logic [7:0] CODE_APER_LAST = 8'hEE;
  localparam logic [7:0] CODE_LITERAL   = 8'hFF;

  // apb register map and reset values
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_LAST     = 8'h08;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_BUSY_BIT = 1;

endpackage

//--- verilog/sad_operand_map.sv
// maps an 8-bit operand code onto its operand kind, index and constant value
`timescale 1ns/1ps
module sad_operand_map
  import sad_pkg::*;
(
  input  logic [7:0]  code_i,
  output sad_opk_t    kind_o,
  output logic [6:0]  index_o,
  output logic [31:0] value_o,
  output logic        literal_o,
  output logic        reserved_o
);

  // code ranges are checked from the bottom up so each branch sees one range
  always_comb
  begin
    kind_o     = OPK_RESERVED;
    index_o    = 7'h00;
    value_o    = 32'h0000_0000;
    literal_o  = 1'b0;
    reserved_o = 1'b0;
    if (code_i <= CODE_SCALAR_GENERAL_REGISTER_LAST)
    begin
      kind_o  = OPK_SCALAR_GENERAL_REGISTER;
      index_o = code_i[6:0];
    end
    else if (code_i == CODE_VECTOR_CONDITION_LOW_HALF)
      kind_o = OPK_VECTOR_CONDITION_LOW_HALF;
    else if (code_i == CODE_VECTOR_CONDITION_HIGH_HALF)
      kind_o = OPK_VECTOR_CONDITION_HIGH_HALF;
    else if (code_i <= CODE_TRAP_LAST)
    begin
      kind_o  = OPK_TRAP;
      index_o = 7'(code_i - CODE_VECTOR_CONDITION_HIGH_HALF - 8'h01);
    end
    else if (code_i == CODE_M0)
      kind_o = OPK_M0;
    else if (code_i == CODE_NULL)
      kind_o = OPK_NULL;
    else if (code_i == CODE_EXECUTE_MASK_LOW_HALF)
      kind_o = OPK_EXECUTE_MASK_LOW_HALF;
    else if (code_i == CODE_EXECUTE_MASK_HIGH_HALF)
      kind_o = OPK_EXECUTE_MASK_HIGH_HALF;
    else if (code_i <= CODE_POS_LAST)
    begin
      kind_o  = OPK_CONST;
      value_o = 32'(code_i - CODE_ZERO);
    end
    else if (code_i <= CODE_NEG_LAST)
    begin
      kind_o  = OPK_CONST;
      value_o = 32'h0000_0000 - 32'(code_i - CODE_POS_LAST);
    end
    else if (code_i >= CODE_APER_1ST && code_i <= CODE_APER_LAST)
    begin
      kind_o  = OPK_APERTURE;
      index_o = 7'(code_i - CODE_APER_1ST);
    end
    else if (code_i == CODE_LITERAL)
    begin
      kind_o    = OPK_LITERAL;
      literal_o = 1'b1;
    end
    else
      reserved_o = 1'b1;
  end

endmodule // sad_operand_map

//--- verilog/sad_decoder.sv
// scalar alu format decoder with literal fetch and apb status registers
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module sad_decoder
  import sad_pkg::*;
(
  input  logic        CLOCK_I,
  input  logic        RST_N_I,
  input  logic        INSTR_VALID_I,
  input  logic [31:0] INSTR_WORD_I,
  output logic        INSTR_READY_O,
  input  logic [31:0] APER_SHARED_APERTURE_BASE_I,
  input  logic [31:0] APER_SHARED_APERTURE_LIMIT_I,
  input  logic [31:0] APER_PRIVATE_APERTURE_BASE_I,
  input  logic [31:0] APER_PRIVATE_APERTURE_LIMIT_I,
  output logic        DEC_VALID_O,
  output sad_fmt_t    DEC_FORMAT_O,
  output logic [7:0]  DEC_OPCODE_O,
  output logic        DEC_ILLEGAL_O,
  output logic        DEC_HAS_LITERAL_O,
  output logic        DEC_SRC0_USED_O,
  output sad_opk_t    DEC_SRC0_KIND_O,
  output logic [6:0]  DEC_SRC0_INDEX_O,
  output logic [31:0] DEC_SRC0_VALUE_O,
  output logic        DEC_SRC1_USED_O,
  output sad_opk_t    DEC_SRC1_KIND_O,
  output logic [6:0]  DEC_SRC1_INDEX_O,
  output logic [31:0] DEC_SRC1_VALUE_O,
  output sad_opk_t    DEC_DST_KIND_O,
  output logic [6:0]  DEC_DST_INDEX_O,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [7:0]  PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR
);

  typedef struct packed {
    sad_st_t     state;
    logic [31:0] word;
    logic        enable;
    logic [15:0] dec_count;
    logic [15:0] ill_count;
    logic [31:0] rdata;
    logic        err;
    logic        valid;
    sad_fmt_t    fmt;
    logic [7:0]  opcode;
    logic        illegal;
    logic        has_lit;
    logic        s0_used;
    sad_opk_t    s0_kind;
    logic [6:0]  s0_idx;
    logic [31:0] s0_val;
    logic        s1_used;
    sad_opk_t    s1_kind;
    logic [6:0]  s1_idx;
    logic [31:0] s1_val;
    sad_opk_t    d_kind;
    logic [6:0]  d_idx;
  } sad_state_t;

  sad_state_t  st_reg;
  sad_state_t  st_next;
  logic [31:0] cur;
  sad_fmt_t    fmt;
  logic [7:0]  opcode;
  logic [7:0]  src1_code;
  sad_opk_t    k0;
  sad_opk_t    k1;
  sad_opk_t    kd;
  logic [6:0]  i0;
  logic [6:0]  i1;
  logic [6:0]  id;
  logic [31:0] v0;
  logic [31:0] v1;
  logic        l0;
  logic        l1;
  logic        r0;
  logic        r1;
  logic        s0_map;
  logic        s1_used;
  logic        need_lit;
  logic        accept;
  logic        idle;

  // longest pattern wins: all three formats share the leading 10
  function automatic sad_fmt_t fmt_of(input logic [31:0] w);
    if (w[31:23] == ONE_SRC_PAT)
      return FMT_ONE_SRC;
    else if (w[31:28] == IMM_PAT)
      return FMT_IMM;
    else if (w[31:30] == TWO_SRC_PAT)
      return FMT_TWO_SRC;
    else
      return FMT_NONE;
  endfunction

  // opcode sits between the format pattern and the destination field, except in the one-source form where it is bits 15:8
  function automatic logic [7:0] opcode_of(input logic [31:0] w, input sad_fmt_t f);
    case (f)
      FMT_TWO_SRC: return {1'b0, w[29:23]};
      FMT_IMM:     return {3'h0, w[27:23]};
      FMT_ONE_SRC: return w[15:8];
      default:     return 8'h00;
    endcase
  endfunction

  // listed opcodes per format; anything else is illegal
  function automatic logic op_legal(input sad_fmt_t f, input logic [7:0] op);
    case (f)
      FMT_TWO_SRC: return (op <= 8'h0B) || (op >= 8'h0E && op <= 8'h2A) || op == 8'h2C
                          || (op >= 8'h2E && op <= 8'h36);
      FMT_IMM:     return (op <= 8'h10) || op == 8'h12 || op == 8'h13 || (op >= 8'h15 && op <= 8'h1C);
      FMT_ONE_SRC: return (op >= 8'h03 && op <= 8'h22) || (op >= 8'h24 && op <= 8'h31) || op == 8'h34
                          || (op >= 8'h37 && op <= 8'h47) || op == 8'h49;
      default:     return 1'b0;
    endcase
  endfunction

  // compare and add/mul immediates read the destination as a second input
  function automatic logic imm_two_input(input logic [7:0] op);
    return op >= 8'h03 && op <= 8'h10;
  endfunction

  // final operand value: constants from the map, apertures and literal from outside
  function automatic logic [31:0] pick_value(input sad_opk_t k, input logic [6:0] idx, input logic [31:0] mv,
                                             input logic [31:0] lit, input logic [31:0] a0, input logic [31:0] a1,
                                             input logic [31:0] a2, input logic [31:0] a3);
    case (k)
      OPK_CONST:    return mv;
      OPK_LITERAL:  return lit;
      OPK_APERTURE: return idx[1] ? (idx[0] ? a3 : a2) : (idx[0] ? a1 : a0);
      default:      return 32'h0000_0000;
    endcase
  endfunction

  // decode the word being taken, or the held word while the literal is awaited
  assign idle      = st_reg.state == ST_IDLE;
  assign cur       = idle ? INSTR_WORD_I : st_reg.word;
  assign fmt       = fmt_of(cur);
  assign opcode    = opcode_of(cur, fmt);
  assign src1_code = (fmt == FMT_IMM) ? {1'b0, cur[22:16]} : cur[15:8];
  assign s0_map    = fmt == FMT_TWO_SRC || fmt == FMT_ONE_SRC;
  assign s1_used   = fmt == FMT_TWO_SRC || (fmt == FMT_IMM && imm_two_input(opcode));
  assign need_lit  = (s0_map && l0) || (fmt == FMT_TWO_SRC && l1);
  assign accept    = INSTR_VALID_I && INSTR_READY_O;

  sad_operand_map u_map_src0 (
    .code_i     (cur[7:0]),
    .kind_o     (k0),
    .index_o    (i0),
    .value_o    (v0),
    .literal_o  (l0),
    .reserved_o (r0)
  );

  sad_operand_map u_map_src1 (
    .code_i     (src1_code),
    .kind_o     (k1),
    .index_o    (i1),
    .value_o    (v1),
    .literal_o  (l1),
    .reserved_o (r1)
  );

  // destination field is seven bits, so only codes 0-127 can be named
  sad_operand_map u_map_dst (
    .code_i     ({1'b0, cur[22:16]}),
    .kind_o     (kd),
    .index_o    (id),
    .value_o    (),
    .literal_o  (),
    .reserved_o ()
  );

  // next state: instruction capture, literal wait, result and apb
  always_comb
  begin
    logic        issue;
    logic [31:0] lit;
    logic        clr;
    issue = 1'b0;
    lit   = 32'h0000_0000;
    clr   = 1'b0;
    st_next = st_reg;
    st_next.valid = 1'b0;
    case (st_reg.state)
      ST_IDLE:
      begin
        if (accept)
        begin
          st_next.word = INSTR_WORD_I;
          if (need_lit)
            st_next.state = ST_LIT;
          else
            issue = 1'b1;
        end
      end
      ST_LIT:
      begin
        if (accept)
        begin
          lit   = INSTR_WORD_I;
          issue = 1'b1;
          st_next.state = ST_IDLE;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
    if (PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL)
      st_next.enable = PWDATA[CTRL_EN_BIT];
    clr = PSEL && PENABLE && PWRITE && PADDR == ADDR_STATUS;
    // a decode in the clearing cycle still counts
    if (clr)
    begin
      st_next.dec_count = 16'h0000;
      st_next.ill_count = 16'h0000;
    end
    if (issue)
    begin
      st_next.valid   = 1'b1;
      st_next.fmt     = fmt;
      st_next.opcode  = opcode;
      st_next.has_lit = need_lit;
      st_next.illegal = !op_legal(fmt, opcode) || (s0_map && r0) || (fmt == FMT_TWO_SRC && r1);
      st_next.s0_used = fmt != FMT_NONE;
      st_next.s0_kind = (fmt == FMT_IMM) ? OPK_IMM : k0;
      st_next.s0_idx  = (fmt == FMT_IMM) ? 7'h00 : i0;
      st_next.s0_val  = (fmt == FMT_IMM) ? {{16{cur[15]}}, cur[15:0]}
                        : pick_value(k0, i0, v0, lit, APER_SHARED_APERTURE_BASE_I, APER_SHARED_APERTURE_LIMIT_I,
                                     APER_PRIVATE_APERTURE_BASE_I, APER_PRIVATE_APERTURE_LIMIT_I);
      st_next.s1_used = s1_used;
      st_next.s1_kind = k1;
      st_next.s1_idx  = i1;
      st_next.s1_val  = pick_value(k1, i1, v1, lit, APER_SHARED_APERTURE_BASE_I, APER_SHARED_APERTURE_LIMIT_I,
                                   APER_PRIVATE_APERTURE_BASE_I, APER_PRIVATE_APERTURE_LIMIT_I);
      st_next.d_kind  = kd;
      st_next.d_idx   = id;
      st_next.dec_count = 16'(st_next.dec_count + 16'h0001);
      if (st_next.illegal)
        st_next.ill_count = 16'(st_next.ill_count + 16'h0001);
    end
    // read data and error latched in the setup phase, answered with no wait
    if (PSEL && !PENABLE)
    begin
      st_next.err   = 1'b0;
      st_next.rdata = 32'h0000_0000;
      if (PADDR == ADDR_CTRL)
      begin
        st_next.rdata[CTRL_EN_BIT]   = st_reg.enable;
        st_next.rdata[CTRL_BUSY_BIT] = !idle;
      end
      else if (PADDR == ADDR_STATUS)
        st_next.rdata = {st_reg.ill_count, st_reg.dec_count};
      else if (PADDR == ADDR_LAST)
        st_next.err = PWRITE;
      else
        st_next.err = 1'b1;
      if (PADDR == ADDR_LAST && !PWRITE)
        st_next.rdata = st_reg.word;
    end
  end

  // single register bank for all state
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      st_reg        <= '0;
      st_reg.state  <= ST_IDLE;
      st_reg.enable <= CTRL_EN_RST;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from the state register, except PREADY tied high and PSLVERR gated by PSEL and PENABLE
  assign INSTR_READY_O     = st_reg.enable;
  assign DEC_VALID_O       = st_reg.valid;
  assign DEC_FORMAT_O      = st_reg.fmt;
  assign DEC_OPCODE_O      = st_reg.opcode;
  assign DEC_ILLEGAL_O     = st_reg.illegal;
  assign DEC_HAS_LITERAL_O = st_reg.has_lit;
  assign DEC_SRC0_USED_O   = st_reg.s0_used;
  assign DEC_SRC0_KIND_O   = st_reg.s0_kind;
  assign DEC_SRC0_INDEX_O  = st_reg.s0_idx;
  assign DEC_SRC0_VALUE_O  = st_reg.s0_val;
  assign DEC_SRC1_USED_O   = st_reg.s1_used;
  assign DEC_SRC1_KIND_O   = st_reg.s1_kind;
  assign DEC_SRC1_INDEX_O  = st_reg.s1_idx;
  assign DEC_SRC1_VALUE_O  = st_reg.s1_val;
  assign DEC_DST_KIND_O    = st_reg.d_kind;
  assign DEC_DST_INDEX_O   = st_reg.d_idx;
  assign PRDATA            = st_reg.rdata;
  assign PREADY            = 1'b1;
  assign PSLVERR           = PSEL && PENABLE && st_reg.err;

  // checks on the decode pipeline
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  sequence take_plain;
    accept && idle && !need_lit;
  endsequence
  sequence take_lit_word;
    accept && !idle;
  endsequence
  plain_issue_a: assert property (take_plain |=> DEC_VALID_O && !DEC_HAS_LITERAL_O)
    else $error("plain instruction not issued next cycle");
  lit_wait_a: assert property (accept && idle && need_lit |=> !DEC_VALID_O && !idle)
    else $error("literal request not waited for");
  lit_value_a: assert property (take_lit_word ##0 (cur[7:0] == CODE_LITERAL && s0_map)
                                |=> DEC_VALID_O && DEC_SRC0_VALUE_O == $past(INSTR_WORD_I))
    else $error("literal word not used as operand");
  one_src_fmt_a: assert property (take_plain ##0 INSTR_WORD_I[31:23] == ONE_SRC_PAT
                                  |=> DEC_FORMAT_O == FMT_ONE_SRC)
    else $error("one-source pattern missed");
  imm_sext_a: assert property (take_plain ##0 fmt == FMT_IMM
                               |=> DEC_SRC0_VALUE_O == {{16{$past(INSTR_WORD_I[15])}}, $past(INSTR_WORD_I[15:0])})
    else $error("immediate not sign-extended");
  two_src_fmt_a: assert property (take_plain ##0 (INSTR_WORD_I[31:30] == TWO_SRC_PAT
                                  && INSTR_WORD_I[31:28] != IMM_PAT) |=> DEC_FORMAT_O == FMT_TWO_SRC)
    else $error("two-source format missed");
  scalar_general_register_src0_a: assert property (take_plain ##0 (s0_map && INSTR_WORD_I[7:0] <= CODE_SCALAR_GENERAL_REGISTER_LAST)
                                |=> DEC_SRC0_KIND_O == OPK_SCALAR_GENERAL_REGISTER && DEC_SRC0_INDEX_O == $past(INSTR_WORD_I[6:0]))
    else $error("register source mapped wrongly");
  pos_const_a: assert property (take_plain ##0 (fmt == FMT_TWO_SRC && INSTR_WORD_I[15:8] > CODE_ZERO
                                && INSTR_WORD_I[15:8] <= CODE_POS_LAST)
                                |=> DEC_SRC1_VALUE_O == 32'($past(INSTR_WORD_I[15:8])) - 32'(CODE_ZERO))
    else $error("inline constant wrong");
  not_scalar_a: assert property (take_plain ##0 INSTR_WORD_I[31:30] != TWO_SRC_PAT |=> DEC_ILLEGAL_O)
    else $error("foreign word not flagged");
  imm_dst_src_a: assert property (DEC_VALID_O && DEC_FORMAT_O == FMT_IMM && DEC_SRC1_USED_O
                                  |-> DEC_SRC1_KIND_O == DEC_DST_KIND_O && DEC_SRC1_INDEX_O == DEC_DST_INDEX_O)
    else $error("immediate second source differs from destination");

endmodule // sad_decoder

//--- tb/sad_issue_model.sv
// instruction issue model that feeds the decoder from a queue of words
`timescale 1ns/1ps
module sad_issue_model
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ready_i,
  output logic             valid_o,
  output logic [31:0]      word_o
);
  logic [31:0] word_q [$];

  // words leave in order, so a literal always follows its own instruction
  task automatic push(input logic [31:0] w);
    word_q.push_back(w);
  endtask

  // an offer holds until taken; idle data toggles so a stale word never looks current
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      valid_o <= 1'b0;
      word_o  <= 32'h0;
    end
    else
    begin
      if (valid_o && ready_i)
        void'(word_q.pop_front());
      if (word_q.size() != 0)
      begin
        valid_o <= 1'b1;
        word_o  <= word_q[0];
      end
      else
      begin
        valid_o <= 1'b0;
        word_o  <= ~word_o;
      end
    end
  end
endmodule // sad_issue_model

//--- tb/testbench.sv
// self-checking bench for the scalar alu format decoder
`timescale 1ns/1ps
module testbench
  import sad_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, iword, s0v, s1v;
  logic        pready, pslverr, ivalid, iready, dvalid, dill, dlit, s0u, s1u;
  logic [7:0]  dop;
  logic [6:0]  s0i, s1i, di;
  sad_fmt_t    dfmt;
  sad_opk_t    s0k, s1k, dk;
  logic [31:0] ap [4] = '{32'hA000_0000, 32'hA0FF_FFFF, 32'hB000_0000, 32'hB0FF_FFFF};
  int          num_errors = 0, total_checks = 0, cycles = 0, n_iss = 0, n_ill = 0;
  localparam logic [7:0] CODES [19] = '{8'h00, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h7B, 8'h7C, 8'h7D, 8'h7E,
    8'h7F, 8'h80, 8'h81, 8'hC0, 8'hC1, 8'hD0, 8'hEB, 8'hEC, 8'hED, 8'hEE};

  sad_issue_model u_sad_issue_model (.clk_i(clk), .rst_n_i(rst_n), .ready_i(iready), .valid_o(ivalid),
    .word_o(iword));
  sad_decoder u_sad_decoder (.CLOCK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(ivalid), .INSTR_WORD_I(iword),
    .INSTR_READY_O(iready), .APER_SHARED_APERTURE_BASE_I(ap[0]), .APER_SHARED_APERTURE_LIMIT_I(ap[1]),
    .APER_PRIVATE_APERTURE_BASE_I(ap[2]), .APER_PRIVATE_APERTURE_LIMIT_I(ap[3]), .DEC_VALID_O(dvalid), .DEC_FORMAT_O(dfmt),
    .DEC_OPCODE_O(dop), .DEC_ILLEGAL_O(dill), .DEC_HAS_LITERAL_O(dlit), .DEC_SRC0_USED_O(s0u),
    .DEC_SRC0_KIND_O(s0k), .DEC_SRC0_INDEX_O(s0i), .DEC_SRC0_VALUE_O(s0v), .DEC_SRC1_USED_O(s1u),
    .DEC_SRC1_KIND_O(s1k), .DEC_SRC1_INDEX_O(s1i), .DEC_SRC1_VALUE_O(s1v), .DEC_DST_KIND_O(dk),
    .DEC_DST_INDEX_O(di), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  always #2 clk = ~clk;

  // hang guard, far above the roughly 130 cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // expected operand kind, index and value of a code
  function automatic sad_opk_t ek(input logic [7:0] c);
    case (c) inside
      [8'h00:8'h69]: return OPK_SCALAR_GENERAL_REGISTER;
      8'h6A: return OPK_VECTOR_CONDITION_LOW_HALF;
      8'h6B: return OPK_VECTOR_CONDITION_HIGH_HALF;
      [8'h6C:8'h7B]: return OPK_TRAP;
      8'h7C: return OPK_M0;
      8'h7D: return OPK_NULL;
      8'h7E: return OPK_EXECUTE_MASK_LOW_HALF;
      8'h7F: return OPK_EXECUTE_MASK_HIGH_HALF;
      [8'h80:8'hD0]: return OPK_CONST;
      [8'hEB:8'hEE]: return OPK_APERTURE;
      8'hFF: return OPK_LITERAL;
      default: return OPK_RESERVED;
    endcase
  endfunction

  function automatic logic [31:0] ev(input logic [7:0] c);
    if (c inside {[8'h80:8'hC0]})
      return {24'h0, c} - 32'h80;
    if (c inside {[8'hC1:8'hD0]})
      return 32'h0 - ({24'h0, c} - 32'hC0);
    if (c inside {[8'hEB:8'hEE]})
      return ap[c - 8'hEB];
    return 32'h0;
  endfunction

  task automatic chk_op(input sad_opk_t k, input logic [6:0] i, input logic [31:0] v, input logic [7:0] c);
    check(32'(k), 32'(ek(c)));
    check(v, ev(c));
    if (ek(c) == OPK_TRAP)
      check(32'(i), 32'(c - 8'h6C));
    else if (ek(c) == OPK_APERTURE)
      check(32'(i), 32'(c - 8'hEB));
    else if (ek(c) == OPK_SCALAR_GENERAL_REGISTER)
      check(32'(i), 32'(c));
  endtask

  // bounded wait for the one-cycle decode pulse, sampled mid-cycle
  task automatic wait_dec();
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (dvalid !== 1'b1 && n < 30);
    check(32'(dvalid), 32'h1);
  endtask

  task automatic issue(input logic [31:0] w);
    @(negedge clk);
    u_sad_issue_model.push(w);
    n_iss++;
    wait_dec();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    // no cap here: the cycle ceiling ends a wait that never answers
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // every listed code in both source slots, destinations spread over the registers
  task automatic s_map();
    for (int i = 0; i < 19; i++)
    begin
      issue({2'b10, 7'h00, 7'(i * 5), CODES[18 - i], CODES[i]});
      check(32'(dfmt), 32'(FMT_TWO_SRC));
      check(32'(dill), 32'h0);
      chk_op(s0k, s0i, s0v, CODES[i]);
      chk_op(s1k, s1i, s1v, CODES[18 - i]);
      check(32'(dk), 32'(OPK_SCALAR_GENERAL_REGISTER));
      check(32'(di), 32'(i * 5));
      check({30'(dlit), s0u, s1u}, 32'h3);
    end
  endtask

  // literal offered late: no result until the extra word is taken
  task automatic s_lit();
    @(negedge clk);
    u_sad_issue_model.push({2'b10, 7'h02, 7'h01, 8'hFF, 8'hFF});
    repeat (4) @(negedge clk);
    check(32'(dvalid), 32'h0);
    issue(32'hCAFE_0123); // instruction and literal count as one decode
    check(32'(dlit), 32'h1);
    check(32'(s0k), 32'(OPK_LITERAL));
    check(s0v, 32'hCAFE_0123);
    check(s1v, 32'hCAFE_0123);
  endtask

  task automatic s_imm();
    issue({4'hB, 5'd15, 7'd20, 16'h8001});
    check(32'(dfmt), 32'(FMT_IMM));
    check(32'(dop), 32'd15);
    check(32'(s0k), 32'(OPK_IMM));
    check(s0v, 32'hFFFF_8001);
    check({s1u, 24'(s1i), 7'(di)}, {1'b1, 24'd20, 7'd20});
    issue({4'hB, 5'd0, 7'd33, 16'h7FFF});
    check({s1u, s0v[30:0]}, {1'b0, 31'h7FFF});
  endtask

  // one-source pattern also begins with 1011, so it must win over the immediate form
  task automatic s_one();
    issue({9'h17D, 7'd9, 8'd3, 8'd130});
    check(32'(dfmt), 32'(FMT_ONE_SRC));
    check({8'(dop), 17'(di), 7'(s0v)}, {8'd3, 17'd9, 7'd2});
  endtask

  task automatic s_bad();
    issue({2'b10, 7'd12, 7'd1, 8'd1, 8'd1});
    check(32'(dill), 32'h1);
    issue({2'b10, 7'd0, 7'd1, 8'd1, 8'd209});
    check(32'(dill), 32'h1);
    issue(32'h0);
    check({30'(dill), 2'(dfmt)}, {30'h1, 2'(FMT_NONE)});
    n_ill += 3;
  endtask

  task automatic s_apb();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, ADDR_CTRL, 32'h0, rd, er);
    check(32'(rd[CTRL_EN_BIT]), 32'(CTRL_EN_RST));
    check(32'(pready), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    check(rd, {16'(n_ill), 16'(n_iss)});
    apb(1'b1, ADDR_STATUS, 32'h0, rd, er);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, er);
    check(rd, 32'h0);
    apb(1'b1, ADDR_LAST, 32'h0, rd, er);
    check(32'(er), 32'h1);
    apb(1'b0, 8'hF0, 32'h0, rd, er);
    check({rd[30:0], er}, 32'h1);
    // disabled decoder must leave the offered word untouched
    apb(1'b1, ADDR_CTRL, 32'h0, rd, er);
    @(negedge clk);
    u_sad_issue_model.push(32'h8000_0102);
    repeat (6)
    begin
      @(negedge clk);
      check({31'(iready), dvalid}, 32'h0);
    end
    apb(1'b1, ADDR_CTRL, 32'h1, rd, er);
    wait_dec();
    apb(1'b0, ADDR_LAST, 32'h0, rd, er);
    check(rd, 32'h8000_0102);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    s_map();
    s_lit();
    s_imm();
    s_one();
    s_bad();
    s_apb();
    print_verdict();
  end
endmodule // testbench
